// file: dmc_defines.svh
// Purpose: Constants for the mode-control and clear-value register block
// Assumes: Included by bare name wherever a constant is needed
// Notes: Bit positions refer to the 24-bit serial frame, MSB first
`ifndef DMC_DEFINES_SVH
`define DMC_DEFINES_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define DMC_FRAME_BITS 24
`define DMC_CNT_SAT 5'h19
`define DMC_CNT_FULL 5'h18
`define DMC_RNW_POS 23
`define DMC_ADDR_HI 22
`define DMC_ADDR_LO 20
`define DMC_DATA_HI 19
`define DMC_CODE_HI 19
`define DMC_CODE_LO 2

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define DMC_ADDR_NOP 3'h0
`define DMC_ADDR_DAC 3'h1
`define DMC_ADDR_CTRL 3'h2
`define DMC_ADDR_CLEAR 3'h3
`define DMC_ADDR_SWCTL 3'h4

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DMC_FB_SEL_POS 1
`define DMC_CLAMP_POS 2
`define DMC_HIZ_POS 3
`define DMC_CODING_POS 4
`define DMC_SDO_DIS_POS 5

// Software control register fields
`define DMC_SW_CLEAR_POS 1
`define DMC_SW_RESET_POS 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DMC_FB_SEL_RST 1'b1
`define DMC_CLAMP_RST 1'b1
`define DMC_HIZ_RST 1'b1
`define DMC_CODING_RST 1'b0
`define DMC_SDO_DIS_RST 1'b0
`define DMC_CLEAR_RST 18'h00000
`define DMC_DAC_RST 18'h00000

`endif

// file: dmc_pkg.sv
// Purpose: Types shared by the mode-control register block
// Assumes: Widths follow dmc_defines.svh
// Notes: Holds types only; numbers live in the defines header
package dmc_pkg;

    // ------------------------------------------------------------------
    // Serial frame as received or returned
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rnw;
        logic [2:0] addr;
        logic [19:0] data;
    } dmc_frame_t;

    // ------------------------------------------------------------------
    // Stored operating-mode fields
    // ------------------------------------------------------------------
    typedef struct packed {
        logic serial_out_disable;
        logic coding_select;
        logic converter_hiz;
        logic output_ground_clamp;
        logic feedback_config_sel;
    } dmc_ctrl_t;

    // Analog-side controls derived from the mode fields
    typedef struct packed {
        logic amp_powered;
        logic feedback_series;
        logic ground_clamp_on;
        logic core_tristate;
    } dmc_analog_t;

endpackage

// file: dmc_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pin levels
// Assumes: Inputs are slow levels from pins
// Notes: Stage one is read only by stage two; callers compare stages two and three
`timescale 1ns/1ps
`default_nettype none

module dmc_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
)(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stage2,
    output logic [WIDTH-1:0] stage3
);

    logic [WIDTH-1:0] stage1_ff;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge sys_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    stage1_ff[gi] <= INIT[gi];
                    stage2[gi] <= INIT[gi];
                    stage3[gi] <= INIT[gi];
                end
                else
                begin
                    stage1_ff[gi] <= async_in[gi];
                    stage2[gi] <= stage1_ff[gi];
                    stage3[gi] <= stage2[gi];
                end
            end
        end
    endgenerate

endmodule // dmc_sync

`default_nettype wire

// file: dmc_link.sv
// Purpose: Serial-clock side of the frame port: shift in, count, shift out
// Assumes: Serial clock runs only while frame select is low
// Notes: Captured frame and count stay still while frame select is high
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.svh"

module dmc_link (
    input wire logic ser_clk,
    input wire logic rstn,
    input wire logic frame_sel_n,
    input wire logic ser_din,
    input wire dmc_pkg::dmc_frame_t rd_word,
    output dmc_pkg::dmc_frame_t rx_frame,
    output logic [4:0] rx_count,
    output logic serial_data_out
);
    import dmc_pkg::*;

    // Frame select high clears the per-frame flags; the clock may be stopped
    logic frame_rst_n;
    logic rx_started_ff;
    logic tx_started_ff;
    logic [22:0] tx_shift_ff;

    assign frame_rst_n = rstn & ~frame_sel_n;

    // ------------------------------------------------------------------
    // Receive on falling edges
    // ------------------------------------------------------------------
    always_ff @(negedge ser_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            rx_started_ff <= 1'b0;
        else
            rx_started_ff <= 1'b1;
    end

    // Count is not cleared by frame select so the system side can read it after
    always_ff @(negedge ser_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_count <= 5'h00;
            rx_frame <= '0;
        end
        else
        begin
            rx_frame <= {rx_frame[22:0], ser_din};
            if (!rx_started_ff)
                rx_count <= 5'h01;
            else if (rx_count != `DMC_CNT_SAT)
                rx_count <= rx_count + 5'h01;
        end
    end

    // ------------------------------------------------------------------
    // Readback on rising edges, host samples on falling
    // ------------------------------------------------------------------
    always_ff @(posedge ser_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
            tx_started_ff <= 1'b0;
        else
            tx_started_ff <= 1'b1;
    end

    always_ff @(posedge ser_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            serial_data_out <= 1'b0;
            tx_shift_ff <= '0;
        end
        else if (!tx_started_ff)
        begin
            serial_data_out <= rd_word[23];
            tx_shift_ff <= rd_word[22:0];
        end
        else
        begin
            serial_data_out <= tx_shift_ff[22];
            tx_shift_ff <= {tx_shift_ff[21:0], 1'b0};
        end
    end

endmodule // dmc_link

`default_nettype wire

// file: dmc_top.sv
// Purpose: Mode-control and clear-value registers of a serially programmed converter
// Assumes: Host drives frame select, serial clock and data; 24 bits per frame
// Notes: Register logic on sys_clk, shifting on the serial clock
//
// Function
// - Mode settings live in the control register, addressed by frame bits 22 to 20.
// - Clear pin or software clear loads the clear value into the output code.
// - Clear-value register is zero after reset.
// - Clear value is coded per the currently selected coding.
// - Feedback-select one, the default: amplifier off, resistors in parallel.
// - Feedback-select zero: amplifier on, resistors in series for gain two.
// - Ground-clamp zero: clamp removed, converter mode set by the tristate bit.
// - Ground-clamp one, the default: output clamped, converter tristated.
// - Every reset returns to clamped and tristated state.
// - Ground-clamp one overrides whatever the tristate bit holds.
// - Tristate bit three: zero normal, one tristate, resets to one.
// - Coding bit four: zero twos complement (default), one offset binary.
// - Bit five: zero serial output enabled (default), one high impedance.
// - Frame bit 23: zero writes, one reads the addressed register.
// - After a read request the next 24 clocks shift out the register.
`timescale 1ns/1ps
`default_nettype none
`include "dmc_defines.svh"

module dmc_top (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ser_clk,
    input wire logic frame_sel_n,
    input wire logic ser_din,
    input wire logic clear_request_n,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output dmc_pkg::dmc_ctrl_t mode_ctrl,
    output dmc_pkg::dmc_analog_t analog_ctrl,
    output logic [17:0] clear_value,
    output logic [17:0] dac_code,
    output logic [17:0] core_code,
    output logic frame_reject
);
    import dmc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic frame_hi_ff;
    logic clear_hi_ff;
    logic frame_end;
    logic clear_pin_active;
    dmc_frame_t rx_frame;
    logic [4:0] rx_count;
    dmc_frame_t rd_word_ff;
    dmc_frame_t nxt_rd_word;
    logic frame_ok;
    logic wr_dac;
    logic wr_ctrl;
    logic wr_clear;
    logic wr_swctl;
    logic rd_req;
    logic soft_rst;
    logic soft_clear;
    dmc_ctrl_t ctrl_ff;
    logic [17:0] clear_ff;
    logic [17:0] dac_ff;
    dmc_analog_t analog_ff;
    logic [17:0] core_ff;
    logic sdo_oe_ff;
    logic reject_ff;
    logic [19:0] ctrl_read;

    // ------------------------------------------------------------------
    // Pin synchronisers: bit 0 frame select, bit 1 clear pin
    // ------------------------------------------------------------------
    dmc_sync #(
        .WIDTH(2),
        .INIT(2'h3)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_in({clear_request_n, frame_sel_n}),
        .stage2(pin_s2),
        .stage3(pin_s3)
    );

    // A level change counts only when stages two and three agree
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            frame_hi_ff <= 1'b1;
        else if (pin_s2[0] == pin_s3[0])
            frame_hi_ff <= pin_s3[0];
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            clear_hi_ff <= 1'b1;
        else if (pin_s2[1] == pin_s3[1])
            clear_hi_ff <= pin_s3[1];
    end

    assign frame_end = pin_s2[0] & pin_s3[0] & ~frame_hi_ff;
    assign clear_pin_active = ~clear_hi_ff;

    // ------------------------------------------------------------------
    // Serial-clock side
    // ------------------------------------------------------------------
    // The received word is stable once frame select is high, so sampling it
    // after the synchronised edge is safe; the readback word is likewise held
    // still across the next frame.
    dmc_link u_link (
        .ser_clk(ser_clk),
        .rstn(rstn),
        .frame_sel_n(frame_sel_n),
        .ser_din(ser_din),
        .rd_word(rd_word_ff),
        .rx_frame(rx_frame),
        .rx_count(rx_count),
        .serial_data_out(serial_data_out)
    );

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    // A frame with 1 to 23 or more than 24 edges is dropped whole; with no edges the last count decides
    assign frame_ok = frame_end && (rx_count == `DMC_CNT_FULL);

    always_comb
    begin
        wr_dac = 1'b0;
        wr_ctrl = 1'b0;
        wr_clear = 1'b0;
        wr_swctl = 1'b0;
        rd_req = 1'b0;
        if (frame_ok)
        begin
            if (rx_frame.rnw)
                rd_req = 1'b1;
            else
            begin
                unique case (rx_frame.addr)
                    `DMC_ADDR_DAC: wr_dac = 1'b1;
                    `DMC_ADDR_CTRL: wr_ctrl = 1'b1;
                    `DMC_ADDR_CLEAR: wr_clear = 1'b1;
                    `DMC_ADDR_SWCTL: wr_swctl = 1'b1;
                    default: wr_dac = 1'b0;
                endcase
            end
        end
    end

    assign soft_rst = wr_swctl && rx_frame.data[`DMC_SW_RESET_POS];
    assign soft_clear = wr_swctl && rx_frame.data[`DMC_SW_CLEAR_POS];

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Reserved bits are expected zero from the host and are not stored
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_ff.feedback_config_sel <= `DMC_FB_SEL_RST;
            ctrl_ff.output_ground_clamp <= `DMC_CLAMP_RST;
            ctrl_ff.converter_hiz <= `DMC_HIZ_RST;
            ctrl_ff.coding_select <= `DMC_CODING_RST;
            ctrl_ff.serial_out_disable <= `DMC_SDO_DIS_RST;
        end
        else if (soft_rst)
        begin
            ctrl_ff.feedback_config_sel <= `DMC_FB_SEL_RST;
            ctrl_ff.output_ground_clamp <= `DMC_CLAMP_RST;
            ctrl_ff.converter_hiz <= `DMC_HIZ_RST;
            ctrl_ff.coding_select <= `DMC_CODING_RST;
            ctrl_ff.serial_out_disable <= `DMC_SDO_DIS_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_ff.feedback_config_sel <= rx_frame.data[`DMC_FB_SEL_POS];
            ctrl_ff.output_ground_clamp <= rx_frame.data[`DMC_CLAMP_POS];
            ctrl_ff.converter_hiz <= rx_frame.data[`DMC_HIZ_POS];
            ctrl_ff.coding_select <= rx_frame.data[`DMC_CODING_POS];
            ctrl_ff.serial_out_disable <= rx_frame.data[`DMC_SDO_DIS_POS];
        end
    end

    // ------------------------------------------------------------------
    // Clear-value register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            clear_ff <= `DMC_CLEAR_RST;
        else if (soft_rst)
            clear_ff <= `DMC_CLEAR_RST;
        else if (wr_clear)
            clear_ff <= rx_frame.data[`DMC_CODE_HI:`DMC_CODE_LO];
    end

    // ------------------------------------------------------------------
    // Converter code register
    // ------------------------------------------------------------------
    // While the clear pin is held low new codes are refused
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            dac_ff <= `DMC_DAC_RST;
        else if (soft_rst)
            dac_ff <= `DMC_DAC_RST;
        else if (clear_pin_active || soft_clear)
            dac_ff <= clear_ff;
        else if (wr_dac)
            dac_ff <= rx_frame.data[`DMC_CODE_HI:`DMC_CODE_LO];
    end

    // Core expects offset binary; twos complement codes get the MSB flipped
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            core_ff <= 18'h00000;
        else
            core_ff <= dac_ff ^ {~ctrl_ff.coding_select, 17'h00000};
    end

    // ------------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            analog_ff.amp_powered <= 1'b0;
            analog_ff.feedback_series <= 1'b0;
            analog_ff.ground_clamp_on <= 1'b1;
            analog_ff.core_tristate <= 1'b1;
        end
        else
        begin
            analog_ff.amp_powered <= ~ctrl_ff.feedback_config_sel;
            analog_ff.feedback_series <= ~ctrl_ff.feedback_config_sel;
            analog_ff.ground_clamp_on <= ctrl_ff.output_ground_clamp;
            // Clamp forces tristate whatever the tristate bit says
            analog_ff.core_tristate <= ctrl_ff.output_ground_clamp
                | ctrl_ff.converter_hiz;
        end
    end

    // ------------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------------
    always_comb
    begin
        ctrl_read = 20'h00000;
        ctrl_read[`DMC_FB_SEL_POS] = ctrl_ff.feedback_config_sel;
        ctrl_read[`DMC_CLAMP_POS] = ctrl_ff.output_ground_clamp;
        ctrl_read[`DMC_HIZ_POS] = ctrl_ff.converter_hiz;
        ctrl_read[`DMC_CODING_POS] = ctrl_ff.coding_select;
        ctrl_read[`DMC_SDO_DIS_POS] = ctrl_ff.serial_out_disable;
    end

    always_comb
    begin
        nxt_rd_word = '0;
        nxt_rd_word.rnw = 1'b1;
        nxt_rd_word.addr = rx_frame.addr;
        unique case (rx_frame.addr)
            `DMC_ADDR_DAC: nxt_rd_word.data = {dac_ff, 2'h0};
            `DMC_ADDR_CTRL: nxt_rd_word.data = ctrl_read;
            `DMC_ADDR_CLEAR: nxt_rd_word.data = {clear_ff, 2'h0};
            default: nxt_rd_word.data = 20'h00000;
        endcase
    end

    // Word is held until the next accepted frame so the link can shift it
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            rd_word_ff <= '0;
        else if (rd_req)
            rd_word_ff <= nxt_rd_word;
        else if (frame_ok)
            rd_word_ff <= '0;
    end

    // ------------------------------------------------------------------
    // Serial output enable and status
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            sdo_oe_ff <= 1'b0;
        else
            sdo_oe_ff <= ~frame_hi_ff & ~ctrl_ff.serial_out_disable;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            reject_ff <= 1'b0;
        else
            reject_ff <= frame_end && (rx_count != `DMC_CNT_FULL);
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign serial_data_out_oe = sdo_oe_ff;
    assign mode_ctrl = ctrl_ff;
    assign analog_ctrl = analog_ff;
    assign clear_value = clear_ff;
    assign dac_code = dac_ff;
    assign core_code = core_ff;
    assign frame_reject = reject_ff;

endmodule // dmc_top

`default_nettype wire

// file: dmc_props.sv
// Purpose: Checker for the mode-control register block
// Assumes: Sees only top ports; frame select and clear pin are asynchronous pins, the rest are in the system clock domain
// Notes: Bound into every dmc_top instance
`timescale 1ns/1ps
`default_nettype none

module dmc_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic frame_sel_n,
    input wire logic clear_request_n,
    input wire logic serial_data_out_oe,
    input wire dmc_pkg::dmc_ctrl_t mode_ctrl,
    input wire dmc_pkg::dmc_analog_t analog_ctrl,
    input wire logic [17:0] clear_value,
    input wire logic [17:0] dac_code,
    input wire logic [17:0] core_code,
    input wire logic frame_reject
);
    import dmc_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // ------
    // Assertions
    // ------
    reset_state_a: assert property ($rose(rstn) |->
        mode_ctrl == 5'h07 && clear_value == 18'h00000)
        else $error("defaults missing after reset");
    // Analog controls lag the fields by one cycle, so skip the release edge
    amp_config_a: assert property ($past(rstn) |->
        analog_ctrl.amp_powered == !$past(mode_ctrl.feedback_config_sel)
        && analog_ctrl.feedback_series == analog_ctrl.amp_powered)
        else $error("amplifier setup wrong");
    ground_clamp_a: assert property ($past(rstn) |->
        analog_ctrl.ground_clamp_on == $past(mode_ctrl.output_ground_clamp))
        else $error("clamp wrong");
    core_tristate_a: assert property ($past(rstn) |->
        analog_ctrl.core_tristate == ($past(mode_ctrl.output_ground_clamp)
        | $past(mode_ctrl.converter_hiz)))
        else $error("tristate wrong");
    coding_map_a: assert property ($past(rstn) |->
        core_code == {$past(dac_code[17]) ^ !$past(mode_ctrl.coding_select),
        $past(dac_code[16:0])})
        else $error("core code coding wrong");
    clear_pin_a: assert property ((!clear_request_n) [*8] |->
        dac_code == $past(clear_value))
        else $error("clear value not applied");
    sdo_disable_a: assert property (serial_data_out_oe |->
        !$past(mode_ctrl.serial_out_disable))
        else $error("serial output driven while disabled");
    sdo_idle_a: assert property (frame_sel_n [*6] |=> !serial_data_out_oe)
        else $error("serial output driven outside frame");
    mode_hold_a: assert property ((!frame_sel_n) [*6] |-> $stable(mode_ctrl))
        else $error("mode changed inside frame");
    reject_pulse_a: assert property (frame_reject |=> !frame_reject)
        else $error("reject longer than one cycle");

    cover property (!mode_ctrl.output_ground_clamp && !mode_ctrl.converter_hiz);
    cover property (frame_reject);
    cover property (serial_data_out_oe ##1 frame_sel_n);
endmodule // dmc_props

bind dmc_top dmc_props i_props (.sys_clk(sys_clk), .rstn(rstn), .frame_sel_n(frame_sel_n),
    .clear_request_n(clear_request_n), .serial_data_out_oe(serial_data_out_oe),
    .mode_ctrl(mode_ctrl), .analog_ctrl(analog_ctrl), .clear_value(clear_value),
    .dac_code(dac_code), .core_code(core_code), .frame_reject(frame_reject));
`default_nettype wire

// file: dmc_host_model.sv
// Purpose: Serial host that frames, clocks and reads the register port
// Assumes: Link clock of 48 ns runs only inside frames
// Notes: A released readback line shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none

module dmc_host_model (
    output logic ser_clk,
    output logic frame_sel_n,
    output logic ser_din,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe
);
    logic last_sdo = 1'b0;

    initial
    begin
        ser_clk = 1'b0;
        frame_sel_n = 1'b1;
        ser_din = 1'b0;
    end

    // ------
    // One frame; edge counts other than 24 only to provoke a refusal
    // ------
    task automatic xfer(input logic [23:0] word, input int edges, output logic [23:0] rdata);
        logic sdo_wire;
        rdata = '0;
        frame_sel_n = 1'b0;
        #17;
        for (int i = 0; i < edges; i++)
        begin
            ser_din = word[23 - (i % 24)];
            #20 ser_clk = 1'b1;
            #24 ser_clk = 1'b0;
            sdo_wire = serial_data_out_oe ? serial_data_out : ~last_sdo;
            last_sdo = sdo_wire;
            rdata = {rdata[22:0], sdo_wire};
            #4;
        end
        #10 frame_sel_n = 1'b1;
        ser_din = ~ser_din;
        #100;
    endtask
endmodule // dmc_host_model
`default_nettype wire

// file: dmc_top_tb_top.sv
// Purpose: Self-checking bench for the mode-control register block
// Assumes: Host model drives the serial port
// Notes: Random fields from a fixed seed plus hand-picked corners
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module dmc_top_tb_top;
    import dmc_pkg::*;
    logic sys_clk, rstn, ser_clk, frame_sel_n, ser_din, clear_request_n;
    logic serial_data_out, serial_data_out_oe, frame_reject;
    dmc_ctrl_t mode_ctrl, c;
    dmc_analog_t analog_ctrl;
    logic [17:0] clear_value, dac_code, core_code, clr, dac;
    logic [23:0] rd;
    logic [31:0] r;
    int mismatches, tests_run, seed, rej_cnt;

    dmc_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .ser_clk(ser_clk), .frame_sel_n(frame_sel_n),
        .ser_din(ser_din), .clear_request_n(clear_request_n), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .mode_ctrl(mode_ctrl),
        .analog_ctrl(analog_ctrl), .clear_value(clear_value), .dac_code(dac_code),
        .core_code(core_code), .frame_reject(frame_reject));
    dmc_host_model i_host (.ser_clk(ser_clk), .frame_sel_n(frame_sel_n), .ser_din(ser_din),
        .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe));

    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Pulse is one cycle wide, so count it on every edge
    always @(posedge sys_clk)
        if (frame_reject === 1'b1)
            rej_cnt <= rej_cnt + 1;

    // ------
    // Expectations and bus tasks
    // ------
    function automatic dmc_analog_t exp_analog(dmc_ctrl_t m);
        return {~m.feedback_config_sel, ~m.feedback_config_sel, m.output_ground_clamp,
            m.output_ground_clamp | m.converter_hiz};
    endfunction

    function automatic logic [17:0] exp_core(logic [17:0] d, logic cod);
        return {d[17] ^ ~cod, d[16:0]};
    endfunction

    task automatic wr(logic [2:0] a, logic [19:0] d);
        i_host.xfer({1'b0, a, d}, 24, rd);
    endtask

    task automatic rd_chk(logic [2:0] a, logic [19:0] d);
        i_host.xfer({1'b1, a, 20'h00000}, 24, rd);
        i_host.xfer(24'h000000, 24, rd);
        `CHK("readback", {1'b1, a, d}, rd)
    endtask

    task automatic chk_all(dmc_ctrl_t m, logic [17:0] cv, logic [17:0] dc);
        `CHK("mode_ctrl", m, mode_ctrl)
        `CHK("analog_ctrl", exp_analog(m), analog_ctrl)
        `CHK("clear_value", cv, clear_value)
        `CHK("dac_code", dc, dac_code)
        `CHK("core_code", exp_core(dc, m.coding_select), core_code)
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (100000) @(posedge sys_clk);
        mismatches++;
        close_out();
    end

    // ------
    // Main sequence
    // ------
    initial
    begin
        seed = 74886;
        mismatches = 0;
        tests_run = 0;
        rej_cnt = 0;
        rstn = 1'b0;
        clear_request_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_all(5'h07, 18'h00000, 18'h00000);
        rd_chk(3'h2, 20'h0000E);
        $display("test defaults done");
        for (int n = 0; n < 8; n++)
        begin
            r = $random(seed);
            c = r[4:0];
            clr = r[22:5];
            r = $random(seed);
            dac = r[17:0];
            // First two passes: fully normal mode, then clamp over cleared tristate
            if (n < 2)
                c = (n == 0) ? 5'h00 : 5'h02;
            wr(3'h2, {14'h0000, c, 1'b0});
            wr(3'h3, {clr, 2'b00});
            wr(3'h1, {dac, 2'b00});
            chk_all(c, clr, dac);
            if (!c.serial_out_disable)
            begin
                rd_chk(3'h2, {14'h0000, c, 1'b0});
                rd_chk(3'h3, {clr, 2'b00});
            end
            @(posedge sys_clk) clear_request_n <= 1'b0;
            repeat (10) @(negedge sys_clk);
            `CHK("clear pin", clr, dac_code)
            @(posedge sys_clk) clear_request_n <= 1'b1;
            repeat (10) @(negedge sys_clk);
            chk_all(c, clr, clr);
            $display("test random %0d done", n);
        end
        wr(3'h1, 20'hFFFFC);
        wr(3'h4, 20'h00002);
        `CHK("soft clear", clr, dac_code)
        wr(3'h2, 20'h0003E);
        i_host.xfer(24'h200000, 23, rd);
        i_host.xfer(24'h200000, 25, rd);
        `CHK("rejects", 2, rej_cnt)
        `CHK("mode kept", 5'h1F, mode_ctrl)
        $display("test bad frames done");
        wr(3'h4, 20'h00004);
        chk_all(5'h07, 18'h00000, 18'h00000);
        wr(3'h2, 20'h00000);
        @(posedge sys_clk) rstn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk_all(5'h07, 18'h00000, 18'h00000);
        $display("test resets done");
        close_out();
    end
endmodule // dmc_top_tb_top
`default_nettype wire
